// ### common/res_defines.vh
`ifndef RES_DEFINES_VH
`define RES_DEFINES_VH
// ------------------------------------------------------------
// register offsets (byte addresses on the plain port)
// ------------------------------------------------------------
`define RES_ADDR_EVENT 12'h124
`define RES_ADDR_COPY 12'h400
`define RES_ADDR_LENGTH 12'h402
`define RES_ADDR_CONFIG 12'h102
`define RES_ADDR_CTRL 12'h104
`define RES_ADDR_IRQ_STATUS 12'h500
`define RES_ADDR_IRQ_MASK 12'h502
// ------------------------------------------------------------
// reset values and fixed fields
// ------------------------------------------------------------
`define RES_EVENT_RESET 16'h0004
`define RES_EVENT_ID 6'h04
`define RES_CONFIG_RESET 16'h0003
`define RES_CTRL_RESET 16'h0005
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RES_BIT_INDIVIDUAL_HASH_FLAG 6
`define RES_BIT_DRIBBLE 7
`define RES_BIT_GOOD 8
`define RES_BIT_HASHED 9
`define RES_BIT_OWNADDR 10
`define RES_BIT_BCAST 11
`define RES_BIT_CRC 12
`define RES_BIT_SHORT 13
`define RES_BIT_OVER 14
`define RES_BIT_DMA_ONLY 9
// ------------------------------------------------------------
// frame length limits in bytes
// ------------------------------------------------------------
`define RES_MIN_LEN 12'd64
`define RES_MAX_LEN 12'd1518
// irq status bits
`define RES_IRQ_GOOD 0
`define RES_IRQ_CRC 1
`define RES_IRQ_SHORT 2
`define RES_IRQ_OVER 3
`endif

// ### hdl/res_event_build.v
`timescale 1ns/1ns
`default_nettype none
`include "res_defines.vh"
// ------------------------------------------------------------
// combinational builder of one event word from frame status
// ------------------------------------------------------------
module res_event_build
(
    input wire [11:0] i_len,
    input wire [2:0] i_dribble_bits,
    input wire i_crc_bad,
    input wire i_hash_hit,
    input wire [5:0] i_hash_index,
    input wire i_own_addr,
    input wire i_bcast,
    input wire i_ia_hash_ctl,
    output reg [15:0] o_word,
    output reg [11:0] o_len
);
    reg short_w;
    reg over_w;
    reg good_w;
    always @*
    begin
        short_w = (i_len < `RES_MIN_LEN);
        over_w = (i_len > `RES_MAX_LEN);
        good_w = ~i_crc_bad & ~short_w & ~over_w; // R6
        // excess bytes beyond the limit are dropped from the count
        o_len = over_w ? `RES_MAX_LEN : i_len; // R17
        o_word = 16'h0000;
        o_word[5:0] = `RES_EVENT_ID; // R1
        o_word[`RES_BIT_DRIBBLE] = (i_dribble_bits != 3'h0); // R4
        o_word[`RES_BIT_GOOD] = good_w; // R6
        o_word[`RES_BIT_HASHED] = i_hash_hit; // R9
        o_word[`RES_BIT_INDIVIDUAL_HASH_FLAG] = i_hash_hit & i_ia_hash_ctl; // R3
        if (i_hash_hit && good_w)
        begin
            o_word[15:10] = i_hash_index; // R10
        end
        else
        begin
            o_word[`RES_BIT_OWNADDR] = i_own_addr; // R11
            o_word[`RES_BIT_BCAST] = i_bcast; // R11
            // alignment error reads as dribble together with bad crc
            o_word[`RES_BIT_CRC] = i_crc_bad; // R5 R16
            o_word[`RES_BIT_SHORT] = short_w; // R16
            o_word[`RES_BIT_OVER] = over_w; // R17
        end
    end
endmodule // res_event_build
`default_nettype wire

// ### hdl/res_receive_event_status.v
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "res_defines.vh"
// Functional notes
// R1: reset 0x0004, low six bits 000100
// R2: read-only event register at 0x124
// R3: bit6 set on hash hit with control
// R4: bit7 set for one-seven dribble bits
// R5: alignment error is dribble plus bad crc
// R6: bit8 set for good crc and length
// R7: good frame length readable at 0x402
// R8: good frame interrupt when enabled
// R9: bit9 set on hash filter accept
// R10: hash index in F..A when hashed good
// R11: otherwise F..A are event flags
// R12: reading event register clears events
// R13: host handles all bits per read
// R14: copy at 0x400 not cleared by read
// R15: contents undefined in dma-only mode
// R16: bad crc and short flags with irqs
// R17: oversize flag, truncate, interrupt; the truncated length is never stored at 0x402
// R18: flags describe latest received frame
module res_receive_event_status
(
    input wire i_clk_sys,
    input wire i_reset,
    input wire [11:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire i_frame_done,
    input wire [11:0] i_frame_len,
    input wire [2:0] i_dribble_bits,
    input wire i_crc_bad,
    input wire i_hash_hit,
    input wire [5:0] i_hash_index,
    input wire i_own_addr,
    input wire i_bcast,
    output reg [15:0] o_rdata,
    output reg o_irq,
    output reg o_dma_only
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [15:0] event_reg;
    reg [15:0] copy_reg;
    reg [11:0] length_reg;
    reg [15:0] config_reg;
    reg [15:0] ctrl_reg;
    reg [3:0] irq_status_reg;
    reg [3:0] irq_mask_reg;
    reg [3:0] irq_status_next;
    reg [15:0] rdata_next;
    reg [3:0] irq_set;
    wire [15:0] new_word;
    wire [11:0] new_len;
    wire rd_event;
    wire wr_irq_status;

    res_event_build u_build
    (
        .i_len(i_frame_len),
        .i_dribble_bits(i_dribble_bits),
        .i_crc_bad(i_crc_bad),
        .i_hash_hit(i_hash_hit),
        .i_hash_index(i_hash_index),
        .i_own_addr(i_own_addr),
        .i_bcast(i_bcast),
        .i_ia_hash_ctl(ctrl_reg[`RES_BIT_INDIVIDUAL_HASH_FLAG]),
        .o_word(new_word),
        .o_len(new_len)
    );

    assign rd_event = i_rd && (i_addr == `RES_ADDR_EVENT);
    assign wr_irq_status = i_wr && (i_addr == `RES_ADDR_IRQ_STATUS);

    // ------------------------------------------------------------
    // event and copy registers
    // ------------------------------------------------------------
    // a frame finishing during a read wins, so its status is not lost
    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            event_reg <= `RES_EVENT_RESET; // R1
            copy_reg <= `RES_EVENT_RESET;
            length_reg <= 12'h000;
        end
        else if (i_frame_done)
        begin
            event_reg <= new_word; // R18
            copy_reg <= new_word; // R14
            if (new_word[`RES_BIT_GOOD])
            begin
                length_reg <= new_len; // R7
            end
        end
        else if (rd_event)
        begin
            event_reg <= `RES_EVENT_RESET; // R12
        end
    end

    // ------------------------------------------------------------
    // configuration and control, writes to event register ignored
    // ------------------------------------------------------------
    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            config_reg <= `RES_CONFIG_RESET;
            ctrl_reg <= `RES_CTRL_RESET;
            irq_mask_reg <= 4'h0;
            o_dma_only <= 1'b0;
        end
        else if (i_wr)
        begin
            case (i_addr) // R2
                `RES_ADDR_CONFIG:
                begin
                    config_reg <= {i_wdata[15:6], `RES_EVENT_ID - 6'h01};
                    // in dma-only mode event contents are not meaningful
                    o_dma_only <= i_wdata[`RES_BIT_DMA_ONLY]; // R15
                end
                `RES_ADDR_CTRL:
                begin
                    ctrl_reg <= {i_wdata[15:6], `RES_EVENT_ID + 6'h01};
                end
                `RES_ADDR_IRQ_MASK:
                begin
                    irq_mask_reg <= i_wdata[3:0];
                end
                default:
                begin
                    irq_mask_reg <= irq_mask_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt status, write one to clear, set wins
    // ------------------------------------------------------------
    always @*
    begin
        irq_set = 4'h0;
        if (i_frame_done)
        begin
            irq_set[`RES_IRQ_GOOD] = new_word[`RES_BIT_GOOD]
                & config_reg[`RES_BIT_GOOD]; // R8
            irq_set[`RES_IRQ_CRC] = i_crc_bad & config_reg[`RES_BIT_CRC]; // R16
            irq_set[`RES_IRQ_SHORT] = (i_frame_len < `RES_MIN_LEN)
                & config_reg[`RES_BIT_SHORT]; // R16
            irq_set[`RES_IRQ_OVER] = (i_frame_len > `RES_MAX_LEN)
                & config_reg[`RES_BIT_OVER]; // R17
        end
        irq_status_next = irq_status_reg;
        if (wr_irq_status)
        begin
            irq_status_next = irq_status_next & ~i_wdata[3:0];
        end
        irq_status_next = irq_status_next | irq_set;
    end

    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            irq_status_reg <= 4'h0;
            o_irq <= 1'b0;
        end
        else
        begin
            irq_status_reg <= irq_status_next;
            o_irq <= |(irq_status_next & irq_mask_reg); // R8
        end
    end

    // ------------------------------------------------------------
    // read port, one cycle latency, unmapped reads as zero
    // ------------------------------------------------------------
    always @*
    begin
        rdata_next = 16'h0000;
        case (i_addr)
            `RES_ADDR_EVENT: rdata_next = event_reg;
            `RES_ADDR_COPY: rdata_next = copy_reg; // R14
            `RES_ADDR_LENGTH: rdata_next = {4'h0, length_reg}; // R7
            `RES_ADDR_CONFIG: rdata_next = config_reg;
            `RES_ADDR_CTRL: rdata_next = ctrl_reg;
            `RES_ADDR_IRQ_STATUS: rdata_next = {12'h000, irq_status_reg};
            `RES_ADDR_IRQ_MASK: rdata_next = {12'h000, irq_mask_reg};
            default: rdata_next = 16'h0000;
        endcase
    end

    always @(posedge i_clk_sys)
    begin
        if (i_reset)
        begin
            o_rdata <= 16'h0000;
        end
        else if (i_rd)
        begin
            o_rdata <= rdata_next;
        end
        else
        begin
            o_rdata <= 16'h0000;
        end
    end
endmodule // res_receive_event_status
`default_nettype wire

// ### testbench/res_receive_event_status_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module res_receive_event_status_chk
(
    input wire i_clk_sys,
    input wire i_reset,
    input wire [11:0] i_addr,
    input wire i_rd,
    input wire i_frame_done,
    input wire [11:0] i_frame_len,
    input wire [2:0] i_dribble_bits,
    input wire i_crc_bad,
    input wire i_hash_hit,
    input wire [5:0] i_hash_index,
    input wire [15:0] o_rdata
);
    wire re = i_rd && i_addr == 12'h124;
    wire rc = i_rd && i_addr == 12'h400;
    wire fg = i_frame_done && !i_crc_bad && i_frame_len >= 12'd64 && i_frame_len <= 12'd1518;
    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_reset);
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 16'h0)
        else $error("read data not zero outside answer");
    event_id_a: assert property (re |=> o_rdata[5:0] == 6'h04)
        else $error("event id bits wrong");
    read_clear_a: assert property ((re && !i_frame_done) ##1 re |=> o_rdata == 16'h0004)
        else $error("event not cleared by read");
    copy_keep_a: assert property ((re && !i_frame_done) ##1 (rc && !i_frame_done)
        |=> o_rdata == $past(o_rdata))
        else $error("copy differs from event");
    good_flag_a: assert property (i_frame_done ##1 re |=> o_rdata[8] == $past(fg, 2))
        else $error("good flag wrong");
    dribble_flag_a: assert property (i_frame_done ##1 re
        |=> o_rdata[7] == ($past(i_dribble_bits, 2) != 3'h0))
        else $error("dribble flag wrong");
    hash_index_a: assert property ((fg && i_hash_hit) ##1 re
        |=> o_rdata[15:10] == $past(i_hash_index, 2))
        else $error("hash index wrong");
    short_flag_a: assert property ((i_frame_done && i_frame_len < 12'd64) ##1 re
        |=> o_rdata[13])
        else $error("short flag missing");
    over_flag_a: assert property ((i_frame_done && i_frame_len > 12'd1518) ##1 re
        |=> o_rdata[14])
        else $error("oversize flag missing");
endmodule // res_receive_event_status_chk
bind res_receive_event_status res_receive_event_status_chk chk (.*);
`default_nettype wire

// ### testbench/tb_res_receive_event_status.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module tb_res_receive_event_status;
    reg i_clk_sys = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_frame_done = 1'b0;
    reg [11:0] i_addr = 12'h0, i_frame_len = 12'h0, l;
    reg [15:0] i_wdata = 16'h0, e, el = 16'h0;
    reg [2:0] i_dribble_bits = 3'h0, d;
    reg i_crc_bad = 1'b0, i_hash_hit = 1'b0, i_own_addr = 1'b0, i_bcast = 1'b0;
    reg [5:0] i_hash_index = 6'h0, x;
    reg c, h, o, b, g, t;
    reg [3:0] m, st;
    wire [15:0] o_rdata;
    wire o_irq, o_dma_only;
    int fails = 0, n_checks = 0, cyc = 0;
    int cl[4] = '{63, 64, 1518, 1519};
    res_receive_event_status dut (.*);
    always #5 i_clk_sys = ~i_clk_sys;
    task report_and_stop;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fails++;
            report_and_stop;
        end
    end
    task wr(input [11:0] a, input [15:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask
    task rd(input [11:0] a, input [15:0] v, input string n);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        `CHK(n, v, o_rdata)
    endtask
    // expected event word of one frame
    function automatic [15:0] ew(input [11:0] n, input [2:0] db, input cb, hh,
        input [5:0] hx, input oa, bc, ct);
        reg gd;
        gd = !cb && n >= 12'd64 && n <= 12'd1518;
        ew = {1'b0, n > 12'd1518, n < 12'd64, cb, bc, oa, hh, gd, db != 3'h0, hh & ct, 6'h04};
        if (gd && hh)
            ew[15:10] = hx;
    endfunction
    initial
    begin
        void'($urandom(32'hc781));
        repeat (10) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        rd(12'h124, 16'h0004, "event");
        rd(12'h400, 16'h0004, "copy");
        rd(12'h102, 16'h0003, "config");
        rd(12'h104, 16'h0005, "ctrl");
        rd(12'h402, 16'h0, "length");
        rd(12'h7fe, 16'h0, "unmapped");
        wr(12'h124, 16'hffff);
        rd(12'h124, 16'h0004, "event after write");
        $display("test reset done");
        wr(12'h102, 16'h7100);
        for (int i = 0; i < 40; i++)
        begin
            t = i < 20;
            m = i[0] ? 4'hf : 4'h0;
            wr(12'h104, t ? 16'h0045 : 16'h0005);
            wr(12'h502, {12'h0, m});
            l = i < 4 ? cl[i] : $urandom % 1600;
            d = $urandom;
            x = $urandom;
            {c, h, o, b} = $urandom;
            c = c & i[1];
            g = !c && l >= 12'd64 && l <= 12'd1518;
            e = ew(l, d, c, h, x, o, b, t);
            if (g)
                el = {4'h0, l};
            st = {l > 12'd1518, l < 12'd64, c, g};
            @(posedge i_clk_sys);
            {i_frame_done, i_frame_len, i_dribble_bits} <= {1'b1, l, d};
            {i_crc_bad, i_hash_hit, i_hash_index, i_own_addr, i_bcast} <= {c, h, x, o, b};
            @(posedge i_clk_sys);
            // back-to-back reads right after the frame, as the checker expects
            i_frame_done <= 1'b0;
            i_addr <= 12'h124;
            i_rd <= 1'b1;
            @(posedge i_clk_sys);
            i_addr <= 12'h400;
            #1;
            `CHK("event word", e, o_rdata)
            @(posedge i_clk_sys);
            i_addr <= 12'h124;
            #1;
            `CHK("copy word", e, o_rdata)
            @(posedge i_clk_sys);
            #1;
            `CHK("cleared event", 16'h0004, o_rdata)
            @(posedge i_clk_sys);
            i_rd <= 1'b0;
            #1;
            `CHK("cleared again", 16'h0004, o_rdata)
            rd(12'h402, el, "length");
            rd(12'h500, {12'h0, st}, "irq status");
            `CHK("irq", |(st & m), o_irq)
            wr(12'h500, 16'h000f);
            @(posedge i_clk_sys);
            #1;
            `CHK("irq cleared", 1'b0, o_irq)
        end
        $display("test frames done");
        wr(12'h102, 16'h0200);
        @(posedge i_clk_sys);
        #1;
        `CHK("dma only", 1'b1, o_dma_only)
        $display("test dma done");
        report_and_stop;
    end
endmodule // tb_res_receive_event_status
`default_nettype wire
